// file: pem_pkg.sv
package pem_pkg;
   localparam int          PEM_REG_AW        = 5;
   localparam int          PEM_DW            = 16;
   localparam int          PEM_NUM_EVT       = 13;
   localparam int          PEM_EVT_LSB       = 3;
   localparam logic [4:0]  PEM_ADDR_STATUS   = 5'h14;
   localparam logic [4:0]  PEM_ADDR_MASK     = 5'h15;
   localparam logic [4:0]  PEM_ADDR_CTRL     = 5'h16;
   localparam logic [4:0]  PEM_ADDR_CLEAR    = 5'h17;
   localparam logic [4:0]  PEM_ADDR_PHYADDR  = 5'h1f;
   localparam logic [4:0]  PEM_BCAST_PHY     = 5'h00;
   localparam int          PEM_BIT_SPEED     = 15;
   localparam int          PEM_BIT_LINK      = 14;
   localparam int          PEM_BIT_DUPLEX    = 13;
   localparam int          PEM_BIT_XOVER     = 12;
   localparam int          PEM_BIT_POL       = 11;
   localparam int          PEM_BIT_PDFAULT   = 10;
   localparam int          PEM_BIT_MSERR     = 9;
   localparam int          PEM_BIT_NOHCD     = 8;
   localparam int          PEM_BIT_NOLINK    = 7;
   localparam int          PEM_BIT_JABBER    = 6;
   localparam int          PEM_BIT_NEXTPAGE  = 5;
   localparam int          PEM_BIT_ANDONE    = 4;
   localparam int          PEM_BIT_RFAULT    = 3;
   localparam int          PEM_BIT_GRST      = 15;
   localparam int          PEM_BIT_BCAST     = 7;
   localparam int          PEM_MODE_LSB      = 0;
   localparam logic [15:0] PEM_EVT_FIELD     = 16'hfff8;
   localparam logic [15:0] PEM_MASK_RST      = 16'h0000;
   localparam logic [15:0] PEM_STATUS_RST    = 16'h0000;
   localparam logic [1:0]  PEM_MODE_RST      = 2'h3;
   typedef enum logic [1:0] {
      PEM_MODE_B8_NOINC = 2'h0,
      PEM_MODE_B8_INC   = 2'h1,
      PEM_MODE_B16_INC  = 2'h2,
      PEM_MODE_B8_WO    = 2'h3
   } pem_mode_e;
endpackage : pem_pkg

// file: pem_edge_detect.sv
`timescale 1ns/1ns
// registers link state and flags a change on any of its bits
module pem_edge_detect
   import pem_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_sys_in,
   input  wire logic         sys_rst_in,
   input  wire logic [W-1:0] level_in,
   output logic              change_out
);
   logic [W-1:0] prev_q;
   logic [W-1:0] prev_d;
   logic         prim_q;
   logic         prim_d;

   initial begin
      if (W < 1) $error("pem_edge_detect: W must be at least 1");
   end

   always_comb begin
      prev_d = level_in;
      // first cycle after reset only primes; no false change
      prim_d = 1'b1;
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prev_q <= '0;
         prim_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         prim_q <= prim_d;
      end
   end

   assign change_out = prim_q && (prev_q != level_in);
endmodule : pem_edge_detect

// file: pem_event_mask.sv
`timescale 1ns/1ns
module pem_event_mask
   import pem_pkg::*;
#(
   parameter int POL_CHANNELS = 4
) (
   input  wire logic                      clk_sys_in,
   input  wire logic                      sys_rst_in,
   // management register port, one cycle per access
   input  wire logic                      reg_wr_in,
   input  wire logic                      reg_rd_in,
   input  wire logic [4:0]                reg_addr_in,
   input  wire logic [4:0]                reg_phy_in,
   input  wire logic [15:0]               reg_wdata_in,
   input  wire logic [4:0]                phy_addr_in,
   output logic      [15:0]               reg_rdata_out,
   output logic                           reg_rvalid_out,
   // link state levels
   input  wire logic [1:0]                link_speed_in,
   input  wire logic                      link_up_in,
   input  wire logic                      full_duplex_in,
   input  wire logic                      xover_swap_in,
   input  wire logic [POL_CHANNELS-1:0]   rx_polarity_in,
   input  wire logic                      jabber_in,
   input  wire logic                      mode_10bt_in,
   input  wire logic                      mode_1000bt_in,
   input  wire logic                      remote_fault_in,
   // one-cycle event pulses
   input  wire logic                      pd_fault_in,
   input  wire logic                      ms_fail_in,
   input  wire logic                      no_hcd_in,
   input  wire logic                      an_no_link_in,
   input  wire logic                      next_page_event_in,
   input  wire logic                      negotiation_done_event_in,
   // device outputs
   output logic                           irq_out,
   output logic                           chip_reset_out,
   output logic                           bcast_en_out,
   output logic      [1:0]                access_mode_out
);
   import pem_pkg::*;

   // package constants must agree with the fixed 16-bit register view
   initial begin
      if (POL_CHANNELS < 1 || POL_CHANNELS > 8)
         $error("pem_event_mask: POL_CHANNELS must be 1..8");
      if (PEM_DW != 16 || PEM_REG_AW != 5)
         $error("pem_event_mask: register view must be 16 by 5 bits");
      if (PEM_EVT_LSB + PEM_NUM_EVT != PEM_DW)
         $error("pem_event_mask: event field must end at the top bit");
   end

   // event status, event mask and control state
   logic [15:0] status_q;
   logic [15:0] status_d;
   logic [15:0] mask_q;
   logic [15:0] mask_d;
   logic        grst_q;
   logic        grst_d;
   logic        bcast_q;
   logic        bcast_d;
   logic [1:0]  mode_q;
   logic [1:0]  mode_d;
   logic        irq_q;
   logic        irq_d;
   // read answer state
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic        rvalid_q;
   logic        rvalid_d;

   // change flags from the level detectors
   logic        spd_chg;
   logic        lnk_chg;
   logic        dpx_chg;
   logic        xov_chg;
   logic        pol_chg;
   logic        rf_chg;
   logic        jab_chg;
   logic [15:0] evt;
   logic        sel_wr;

   // one write decode shared by every writable register
   function automatic logic wr_hit(input logic       sel,
                                   input logic [4:0] addr,
                                   input logic [4:0] target);
      wr_hit = sel && (addr == target);
   endfunction : wr_hit

   function automatic logic addressed(input logic [4:0] phy,
                                      input logic       wr,
                                      input logic       bc,
                                      input logic [4:0] own);
      addressed = (phy == own) || (wr && bc && phy == PEM_BCAST_PHY);
   endfunction : addressed

   // one detector per level input except the mode_10bt_in and mode_1000bt_in qualifiers; any changed bit is one event

   pem_edge_detect #(.W(2)) u_spd (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (link_speed_in),
      .change_out (spd_chg)
   );
   pem_edge_detect #(.W(1)) u_lnk (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (link_up_in),
      .change_out (lnk_chg)
   );
   pem_edge_detect #(.W(1)) u_dpx (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (full_duplex_in),
      .change_out (dpx_chg)
   );
   pem_edge_detect #(.W(1)) u_xov (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (xover_swap_in),
      .change_out (xov_chg)
   );

   // all receive channels share one flag: any flip sets bit 11
   pem_edge_detect #(.W(POL_CHANNELS)) u_pol (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (rx_polarity_in),
      .change_out (pol_chg)
   );

   // jabber changes are qualified by 10BASE-T mode further down
   pem_edge_detect #(.W(1)) u_jab (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (jabber_in),
      .change_out (jab_chg)
   );
   pem_edge_detect #(.W(1)) u_rf (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (remote_fault_in),
      .change_out (rf_chg)
   );

   always_comb begin
      evt                   = '0;
      // speed changes count only while a link is established
      evt[PEM_BIT_SPEED]    = spd_chg && link_up_in;
      evt[PEM_BIT_LINK]     = lnk_chg;
      evt[PEM_BIT_DUPLEX]   = dpx_chg;
      evt[PEM_BIT_XOVER]    = xov_chg;
      evt[PEM_BIT_POL]      = pol_chg;
      evt[PEM_BIT_PDFAULT]  = pd_fault_in;
      evt[PEM_BIT_MSERR]    = ms_fail_in && mode_1000bt_in;
      evt[PEM_BIT_NOHCD]    = no_hcd_in;
      evt[PEM_BIT_NOLINK]   = an_no_link_in;
      evt[PEM_BIT_JABBER]   = jab_chg && mode_10bt_in;
      evt[PEM_BIT_NEXTPAGE] = next_page_event_in;
      evt[PEM_BIT_ANDONE]   = negotiation_done_event_in;
      evt[PEM_BIT_RFAULT]   = rf_chg;
   end

   always_comb begin
      sel_wr   = reg_wr_in && addressed(reg_phy_in, 1'b1, bcast_q,
                                        phy_addr_in);
      status_d = status_q;
      mask_d   = mask_q;
      bcast_d  = bcast_q;
      mode_d   = mode_q;
      // reset request lasts one cycle; control reads never return it, so it reads as zero
      grst_d   = 1'b0;
      // writes to the status address fall through and are ignored
      if (wr_hit(sel_wr, reg_addr_in, PEM_ADDR_CLEAR))
         status_d = status_d & ~reg_wdata_in;
      // set after clear: a same-cycle event survives the clear
      status_d = (status_d | evt) & PEM_EVT_FIELD;
      if (wr_hit(sel_wr, reg_addr_in, PEM_ADDR_MASK))
         mask_d = reg_wdata_in & PEM_EVT_FIELD;
      if (wr_hit(sel_wr, reg_addr_in, PEM_ADDR_CTRL)) begin
         grst_d  = reg_wdata_in[PEM_BIT_GRST];
         bcast_d = reg_wdata_in[PEM_BIT_BCAST];
         mode_d  = reg_wdata_in[PEM_MODE_LSB +: 2];
      end
      // built from next values so irq follows a write at its own edge
      irq_d = |(status_d & mask_d);
   end

   always_comb begin
      rvalid_d = reg_rd_in && addressed(reg_phy_in, 1'b0, bcast_q,
                                        phy_addr_in);
      rdata_d  = '0;
      if (rvalid_d) begin
         unique case (reg_addr_in)
            PEM_ADDR_STATUS: rdata_d = status_q;
            PEM_ADDR_MASK:   rdata_d = mask_q;
            PEM_ADDR_CTRL: begin
               rdata_d[PEM_BIT_BCAST]        = bcast_q;
               rdata_d[PEM_MODE_LSB +: 2]    = mode_q;
            end
            // clear register bits self-clear, so always read zero
            default:         rdata_d = '0;
         endcase
      end
   end

   // register state; the chip reset pulse does not reset this block
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_q <= PEM_STATUS_RST;
         mask_q   <= PEM_MASK_RST;
         grst_q   <= 1'b0;
         bcast_q  <= 1'b0;
         mode_q   <= PEM_MODE_RST;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
         grst_q   <= grst_d;
         bcast_q  <= bcast_d;
         mode_q   <= mode_d;
         irq_q    <= irq_d;
      end
   end

   // read answer: one cycle, data zero whenever no answer stands
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata_out   = rdata_q;
   assign reg_rvalid_out  = rvalid_q;
   assign irq_out         = irq_q;
   assign chip_reset_out  = grst_q;
   assign bcast_en_out    = bcast_q;
   assign access_mode_out = mode_q;
endmodule : pem_event_mask

// file: pem_event_mask_sva.sv
`timescale 1ns/1ns
module pem_event_mask_chk
   import pem_pkg::*;
(
   input wire logic        clk_sys_in,
   input wire logic        sys_rst_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [4:0]  reg_addr_in,
   input wire logic [4:0]  reg_phy_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [4:0]  phy_addr_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic        reg_rvalid_out,
   input wire logic        irq_out,
   input wire logic        chip_reset_out,
   input wire logic        bcast_en_out,
   input wire logic [1:0]  access_mode_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   wire own = reg_phy_in == phy_addr_in;
   chk_read_answer: assert property (
      reg_rd_in && own && reg_addr_in == PEM_ADDR_STATUS |=> reg_rvalid_out)
      else $error("status read not answered");
   chk_read_refused: assert property (
      reg_rd_in && !own |=> !reg_rvalid_out)
      else $error("foreign read answered");
   chk_reserved_zero: assert property (
      reg_rvalid_out && $past(reg_addr_in) != PEM_ADDR_CTRL
      |-> reg_rdata_out[2:0] == 3'h0) else $error("reserved bits set");
   chk_mask_off: assert property (
      reg_wr_in && own && reg_addr_in == PEM_ADDR_MASK
      && reg_wdata_in == 16'h0000 |=> !irq_out)
      else $error("irq with all masked");
   chk_reset_pulse: assert property (
      reg_wr_in && own && reg_addr_in == PEM_ADDR_CTRL
      && reg_wdata_in[PEM_BIT_GRST] |=> chip_reset_out)
      else $error("no chip reset pulse");
   chk_reset_cause: assert property (
      chip_reset_out |-> $past(reg_wr_in && reg_addr_in == PEM_ADDR_CTRL))
      else $error("chip reset without write");
   chk_bcast_write: assert property (
      reg_wr_in && reg_phy_in == PEM_BCAST_PHY && bcast_en_out
      && reg_addr_in == PEM_ADDR_CTRL
      |=> access_mode_out == $past(reg_wdata_in[1:0]))
      else $error("broadcast write lost");
   chk_mode_hold: assert property (
      !reg_wr_in |=> $stable(access_mode_out))
      else $error("mode changed without write");
   chk_irq_sticky: assert property (
      irq_out && !reg_wr_in |=> irq_out) else $error("irq dropped alone");
endmodule : pem_event_mask_chk

// file: pem_sta_model.sv
`timescale 1ns/1ns
module pem_sta_model
   import pem_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic [15:0] reg_rdata_in,
   input  wire logic        reg_rvalid_in,
   output logic             reg_wr_out,
   output logic             reg_rd_out,
   output logic      [4:0]  reg_addr_out,
   output logic      [4:0]  reg_phy_out,
   output logic      [15:0] reg_wdata_out
);
   initial begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = 5'h00;
      reg_phy_out = 5'h00;
      reg_wdata_out = 16'h0000;
   end
   // one strobe cycle; the read answer stands from the taking edge on
   task automatic access(input logic w, input logic [4:0] p, a,
                         input logic [15:0] d, output logic [15:0] q,
                         output logic ok);
      @(posedge clk_sys_in);
      #1;
      reg_wr_out = w;
      reg_rd_out = !w;
      reg_phy_out = p;
      reg_addr_out = a;
      reg_wdata_out = d;
      @(posedge clk_sys_in);
      #1;
      // sampled while settled, before the next edge removes it
      if (!w) begin
         q = reg_rdata_in;
         ok = reg_rvalid_in;
      end
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      // idle address and data lines carry no stale value; reg_phy_out keeps p
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask : access
endmodule : pem_sta_model

// file: test_pem_event_mask.sv
`timescale 1ns/1ns
module test_pem_event_mask;
   import pem_pkg::*;
   localparam logic [4:0] own_phy = 5'h05;
   logic clk_sys_in, sys_rst_in, reg_wr, reg_rd, rvalid, irq, grst, bcast;
   logic qual, ok;
   logic [4:0] addr, phy;
   logic [15:0] wdata, rdata, poke, q;
   logic [1:0] mode;
   int failures = 0;
   int checks_done = 0;
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   pem_event_mask i_dut (.clk_sys_in, .sys_rst_in, .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_phy_in(phy),
      .reg_wdata_in(wdata), .phy_addr_in(own_phy), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .link_speed_in({1'b1, poke[15]}),
      .link_up_in(~poke[14]), .full_duplex_in(poke[13]),
      .xover_swap_in(poke[12]), .rx_polarity_in({3'h0, poke[11]}),
      .jabber_in(poke[6]), .mode_10bt_in(qual), .mode_1000bt_in(qual),
      .remote_fault_in(poke[3]), .pd_fault_in(poke[10]),
      .ms_fail_in(poke[9]), .no_hcd_in(poke[8]), .an_no_link_in(poke[7]),
      .next_page_event_in(poke[5]), .negotiation_done_event_in(poke[4]),
      .irq_out(irq), .chip_reset_out(grst), .bcast_en_out(bcast),
      .access_mode_out(mode));
   pem_sta_model i_sta (.clk_sys_in, .reg_rdata_in(rdata),
      .reg_rvalid_in(rvalid), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
      .reg_addr_out(addr), .reg_phy_out(phy), .reg_wdata_out(wdata));
   task automatic wr(input logic [4:0] p, a, input logic [15:0] d);
      i_sta.access(1'b1, p, a, d, q, ok);
   endtask : wr
   task automatic rd(input logic [4:0] p, a);
      i_sta.access(1'b0, p, a, 16'h0000, q, ok);
   endtask : rd
   task automatic chk_word(input string n, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string n, input logic e, g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   task automatic give_verdict;
      if (failures == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // levels flip and return, so each gives two changes on one bit
   task automatic poke_bit(input int b);
      @(posedge clk_sys_in);
      #1;
      poke = 16'h0001 << b;
      @(posedge clk_sys_in);
      #1;
      poke = 16'h0000;
   endtask : poke_bit
   initial begin
      poke = 16'h0000;
      qual = 1'b1;
      sys_rst_in = 1'b1;
      repeat (4) @(posedge clk_sys_in);
      #1;
      sys_rst_in = 1'b0;
      chk_word("mode", 16'h0003, {14'h0000, mode});
      rd(own_phy, PEM_ADDR_MASK);
      chk_word("mask", 16'h0000, q);
      rd(own_phy, PEM_ADDR_CTRL);
      chk_word("ctrl", 16'h0003, q);
      rd(own_phy, 5'h10);
      chk_word("unmapped", 16'h0000, q);
      wr(own_phy, PEM_ADDR_MASK, 16'hfff8);
      rd(own_phy, PEM_ADDR_MASK);
      chk_word("mask", 16'hfff8, q);
      for (int b = 15; b >= 3; b--) begin
         poke_bit(b);
         repeat (3) @(posedge clk_sys_in);
         rd(own_phy, PEM_ADDR_STATUS);
         chk_word("status", 16'h0001 << b, q);
         chk_bit("irq", 1'b1, irq);
         wr(own_phy, PEM_ADDR_CLEAR, 16'h0001 << b);
         rd(own_phy, PEM_ADDR_STATUS);
         chk_word("cleared", 16'h0000, q);
         chk_bit("irq", 1'b0, irq);
      end
      qual = 1'b0;
      poke_bit(PEM_BIT_JABBER);
      poke_bit(PEM_BIT_MSERR);
      rd(own_phy, PEM_ADDR_STATUS);
      chk_word("unqualified", 16'h0000, q);
      poke_bit(PEM_BIT_ANDONE);
      wr(own_phy, PEM_ADDR_MASK, 16'h0000);
      chk_bit("irq", 1'b0, irq);
      wr(own_phy, PEM_ADDR_MASK, 16'h0010);
      chk_bit("irq", 1'b1, irq);
      wr(own_phy, PEM_ADDR_CTRL, 16'h8082);
      chk_bit("grst", 1'b1, grst);
      rd(own_phy, PEM_ADDR_CTRL);
      chk_word("ctrl", 16'h0082, q);
      chk_bit("grst", 1'b0, grst);
      for (int m = 0; m < 4; m++) begin
         wr(PEM_BCAST_PHY, PEM_ADDR_CTRL, {14'h0020, m[1:0]});
         chk_word("mode", {14'h0000, m[1:0]}, {14'h0000, mode});
      end
      wr(PEM_BCAST_PHY, PEM_ADDR_CTRL, 16'h0001);
      chk_bit("bcast", 1'b0, bcast);
      wr(PEM_BCAST_PHY, PEM_ADDR_CTRL, 16'h0082);
      chk_word("mode", 16'h0001, {14'h0000, mode});
      rd(5'h06, PEM_ADDR_STATUS);
      chk_bit("rvalid", 1'b0, ok);
      rd(PEM_BCAST_PHY, PEM_ADDR_STATUS);
      chk_bit("bcast rvalid", 1'b0, ok);
      // event and clear meet in one cycle: the event must survive
      fork
         poke_bit(PEM_BIT_ANDONE);
         wr(own_phy, PEM_ADDR_CLEAR, 16'h0010);
      join
      rd(own_phy, PEM_ADDR_STATUS);
      chk_word("set wins", 16'h0010, q);
      wr(own_phy, PEM_ADDR_CLEAR, 16'h0010);
      rd(own_phy, PEM_ADDR_STATUS);
      chk_word("cleared", 16'h0000, q);
      sys_rst_in = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1;
      sys_rst_in = 1'b0;
      chk_word("mode", 16'h0003, {14'h0000, mode});
      rd(own_phy, PEM_ADDR_MASK);
      chk_word("mask", 16'h0000, q);
      give_verdict;
   end
   initial begin
      #100000;
      failures++;
      give_verdict;
   end
endmodule : test_pem_event_mask
bind pem_event_mask pem_event_mask_chk i_chk (.clk_sys_in, .sys_rst_in,
   .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_phy_in, .reg_wdata_in,
   .phy_addr_in, .reg_rdata_out, .reg_rvalid_out, .irq_out,
   .chip_reset_out, .bcast_en_out, .access_mode_out);
